// ---- hdl/sdwp_top.sv ----
`timescale 1ns/1ps
module sdwp_top
  import sdwp_pkg::*;
#(
  // Word format is fixed; other sizes are refused below
  parameter int WORD_BITS = SDWP_WORD_BITS,
  parameter int CODE_BITS = SDWP_CODE_BITS
)
(
  input wire logic clk,
  input wire logic reset,
  input wire logic frame_sel_n,
  input wire logic sclk,
  input wire logic sdata,
  output logic [15:0] dac_code,
  output logic [1:0] power_mode,
  output logic power_mode_hi,
  output logic power_mode_lo,
  output logic analog_output_en,
  output logic pulldown_1k,
  output logic pulldown_100k,
  output logic update_pulse
);
  sdwp_sync_if sync_bus();

  // The shift path and outputs are sized for one word format only
  if (WORD_BITS != SDWP_WORD_BITS || CODE_BITS != SDWP_CODE_BITS) begin : g_bad_size
    $error("sdwp_top supports only a 24-bit word with a 16-bit code");
  end

  sdwp_pin_sync u_sync (
    .clk(clk),
    .reset(reset),
    .frame_sel_n(frame_sel_n),
    .sclk(sclk),
    .sdata(sdata),
    .sync(sync_bus.src)
  );

  sdwp_state_t state_ff, nxt_state;
  logic [23:0] shift_ff, nxt_shift;
  logic [4:0] cnt_ff, nxt_cnt;
  logic [15:0] code_ff, nxt_code;
  sdwp_mode_t mode_ff, nxt_mode;
  logic upd_ff, nxt_upd;
  // Mode pins are registered so they switch in the same cycle as the code
  logic out_en_ff, nxt_out_en;
  logic pd_1k_ff, nxt_pd_1k;
  logic pd_100k_ff, nxt_pd_100k;

  // Frame sequencing, shifting and load on the last edge
  always_comb begin
    nxt_state = state_ff;
    nxt_shift = shift_ff;
    nxt_cnt = cnt_ff;
    nxt_code = code_ff;
    nxt_mode = mode_ff;
    nxt_upd = 1'b0;
    case (state_ff)
      SDWP_IDLE: begin
        if (sync_bus.frame_start) begin
          nxt_state = SDWP_SHIFT;
          nxt_shift = SDWP_SHIFT_RST;
          nxt_cnt = SDWP_CNT_RST;
        end
      end
      SDWP_SHIFT: begin
        if (sync_bus.frame_end) begin
          // Early rise: drop the partial word, outputs untouched
          nxt_state = SDWP_IDLE;
          nxt_shift = SDWP_SHIFT_RST;
          nxt_cnt = SDWP_CNT_RST;
        end else if (sync_bus.sclk_fall) begin
          nxt_shift = {shift_ff[22:0], sync_bus.data_bit};
          nxt_cnt = cnt_ff + 5'h01;
          if (cnt_ff == 5'(SDWP_WORD_BITS - 1)) begin
            // Last bit not shifted yet, so mode and code sit one place low
            nxt_code = {shift_ff[SDWP_CODE_BITS-2:0], sync_bus.data_bit};
            nxt_mode = sdwp_mode_t'(shift_ff[SDWP_MODE_LSB -: 2]);
            nxt_upd = 1'b1;
            nxt_state = SDWP_DONE;
          end
        end
      end
      SDWP_DONE: begin
        // Further clocks ignored until select goes high again
        if (!sync_bus.frame_active) begin
          nxt_state = SDWP_IDLE;
          nxt_cnt = SDWP_CNT_RST;
        end
      end
      default: nxt_state = SDWP_IDLE;
    endcase
    // Decode from the next mode so pins and code change together
    nxt_out_en = (nxt_mode == SDWP_PM_NORMAL);
    nxt_pd_1k = (nxt_mode == SDWP_PM_1K);
    nxt_pd_100k = (nxt_mode == SDWP_PM_100K);
  end

  // Reset forces zero code and normal mode
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      state_ff <= SDWP_IDLE;
      shift_ff <= SDWP_SHIFT_RST;
      cnt_ff <= SDWP_CNT_RST;
      code_ff <= SDWP_CODE_RST;
      mode_ff <= SDWP_PM_NORMAL;
      upd_ff <= 1'b0;
      out_en_ff <= 1'b1;
      pd_1k_ff <= 1'b0;
      pd_100k_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      shift_ff <= nxt_shift;
      cnt_ff <= nxt_cnt;
      code_ff <= nxt_code;
      mode_ff <= nxt_mode;
      upd_ff <= nxt_upd;
      out_en_ff <= nxt_out_en;
      pd_1k_ff <= nxt_pd_1k;
      pd_100k_ff <= nxt_pd_100k;
    end
  end

  // Mode decode for the analog side
  assign dac_code = code_ff;
  assign power_mode = mode_ff;
  assign power_mode_hi = mode_ff[1];
  assign power_mode_lo = mode_ff[0];
  assign analog_output_en = out_en_ff;
  assign pulldown_1k = pd_1k_ff;
  assign pulldown_100k = pd_100k_ff;
  assign update_pulse = upd_ff;

  // Counts edges apart from the frame logic, so the update check does not echo it
  logic [4:0] edge_seen_ff, nxt_edge_seen;
  always_comb begin
    nxt_edge_seen = edge_seen_ff;
    if (sync_bus.frame_start) begin
      nxt_edge_seen = 5'h00;
    end else if (sync_bus.sclk_fall && sync_bus.frame_active && edge_seen_ff != 5'h1f) begin
      nxt_edge_seen = edge_seen_ff + 5'h01;
    end
  end

  // Saturates so a long run of clocks cannot wrap back to 23
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      edge_seen_ff <= 5'h00;
    end else begin
      edge_seen_ff <= nxt_edge_seen;
    end
  end

  // Named steps of a frame for the checks below
  sequence s_abort;
    state_ff == SDWP_SHIFT && sync_bus.frame_end;
  endsequence

  sequence s_last_edge;
    state_ff == SDWP_SHIFT && sync_bus.frame_active && sync_bus.sclk_fall
      && cnt_ff == 5'h17;
  endsequence

  a_update_on_24th: assert property (@(posedge clk) disable iff (reset)
    update_pulse |-> $past(edge_seen_ff) == 5'd23 && edge_seen_ff == 5'd24)
    else $error("update not on 24th edge");

  a_abort_no_update: assert property (@(posedge clk) disable iff (reset)
    s_abort |=> $stable(dac_code) && $stable(power_mode) && !update_pulse)
    else $error("abort changed outputs");

  a_abort_clears_shift: assert property (@(posedge clk) disable iff (reset)
    s_abort |=> shift_ff == SDWP_SHIFT_RST && state_ff == SDWP_IDLE)
    else $error("abort did not clear shift register");

  a_code_only_on_update: assert property (@(posedge clk) disable iff (reset)
    !$stable(dac_code) |-> update_pulse)
    else $error("code changed without update");

  a_shift_on_fall: assert property (@(posedge clk) disable iff (reset)
    (state_ff == SDWP_SHIFT && sync_bus.frame_active && sync_bus.sclk_fall)
      |=> shift_ff[0] == $past(sync_bus.data_bit))
    else $error("bit not shifted in");

  a_idle_holds_shift: assert property (@(posedge clk) disable iff (reset)
    (state_ff == SDWP_IDLE && !sync_bus.frame_start) |=> state_ff == SDWP_IDLE)
    else $error("frame opened without select low");

  a_mode_decode: assert property (@(posedge clk) disable iff (reset)
    $onehot({analog_output_en, pulldown_1k, pulldown_100k, mode_ff == SDWP_PM_HIZ}))
    else $error("mode decode not one-hot");

  a_code_lsb_last: assert property (@(posedge clk) disable iff (reset)
    update_pulse |-> dac_code[0] == $past(sync_bus.data_bit, 1))
    else $error("last bit not code lsb");

  // Load, pulse width and clocks after the word
  a_load_after_24th: assert property (@(posedge clk) disable iff (reset)
    s_last_edge |=> update_pulse
      && dac_code[0] == $past(sync_bus.data_bit))
    else $error("word not loaded after the 24th edge");

  a_pulse_one_cycle: assert property (@(posedge clk) disable iff (reset)
    update_pulse |=> !update_pulse)
    else $error("update pulse longer than one cycle");

  a_done_ignores_clk: assert property (@(posedge clk) disable iff (reset)
    (state_ff == SDWP_DONE && sync_bus.sclk_fall)
      |=> $stable(dac_code) && $stable(power_mode))
    else $error("clock after the 24th edge changed outputs");

  a_mode_from_word: assert property (@(posedge clk) disable iff (reset)
    s_last_edge |=> power_mode == $past(shift_ff[16:15]))
    else $error("power mode not taken from its word position");

  a_decode_match: assert property (@(posedge clk) disable iff (reset)
    analog_output_en == (power_mode == 2'b00) && pulldown_1k == (power_mode == 2'b01)
      && pulldown_100k == (power_mode == 2'b10))
    else $error("power mode pins disagree with the mode");

  a_start_clears_cnt: assert property (@(posedge clk) disable iff (reset)
    (state_ff == SDWP_IDLE && sync_bus.frame_start)
      |=> state_ff == SDWP_SHIFT && cnt_ff == SDWP_CNT_RST)
    else $error("frame open did not clear the bit count");
endmodule

// ---- hdl/sdwp_pkg.sv ----
package sdwp_pkg;
  localparam int SDWP_WORD_BITS = 24;
  localparam int SDWP_CODE_BITS = 16;
  localparam int SDWP_MODE_LSB = 16;
  localparam int SDWP_CLK_PERIOD_PS = 5000;
  localparam int SDWP_FRAME_GAP_NS = 100;
  localparam int SDWP_FRAME_GAP_CYC =
    (SDWP_FRAME_GAP_NS * 1000 + SDWP_CLK_PERIOD_PS - 1) / SDWP_CLK_PERIOD_PS;
  localparam logic [15:0] SDWP_CODE_RST = 16'h0000;
  localparam logic [4:0] SDWP_CNT_RST = 5'h00;
  localparam logic [23:0] SDWP_SHIFT_RST = 24'h00_0000;

  typedef enum logic [1:0] {
    SDWP_PM_NORMAL = 2'b00,
    SDWP_PM_1K = 2'b01,
    SDWP_PM_100K = 2'b10,
    SDWP_PM_HIZ = 2'b11
  } sdwp_mode_t;

  typedef enum logic [1:0] {
    SDWP_IDLE = 2'b00,
    SDWP_SHIFT = 2'b01,
    SDWP_DONE = 2'b10
  } sdwp_state_t;
endpackage

// ---- hdl/sdwp_sync_if.sv ----
`timescale 1ns/1ps
// Synchronised pin levels and edge events passed to the frame logic
interface sdwp_sync_if;
  logic frame_active;
  logic frame_start;
  logic frame_end;
  logic sclk_fall;
  logic data_bit;
  modport src (output frame_active, output frame_start, output frame_end, output sclk_fall,
    output data_bit);
  modport dst (input frame_active, input frame_start, input frame_end, input sclk_fall,
    input data_bit);
endinterface

// ---- hdl/sdwp_pin_sync.sv ----
`timescale 1ns/1ps
module sdwp_pin_sync
  import sdwp_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic frame_sel_n,
  input wire logic sclk,
  input wire logic sdata,
  sdwp_sync_if.src sync
);
  logic [2:0] s1_ff;
  logic [2:0] s2_ff;
  logic [2:0] s3_ff;
  logic [2:0] nxt_s1;

  // Two stages per pin, third stage for edge detection and the data sample
  always_comb begin
    nxt_s1 = {frame_sel_n, sclk, sdata};
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      s1_ff <= 3'h7;
      s2_ff <= 3'h7;
      s3_ff <= 3'h7;
    end else begin
      s1_ff <= nxt_s1;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
    end
  end

  // Select low opens a frame; data is the level already settled with the clock
  assign sync.frame_active = !s2_ff[2];
  assign sync.frame_start = !s2_ff[2] && s3_ff[2];
  assign sync.frame_end = s2_ff[2] && !s3_ff[2];
  assign sync.sclk_fall = !s2_ff[1] && s3_ff[1];
  assign sync.data_bit = s3_ff[0]; // Sampled one stage late to match the clock edge
endmodule

// ---- tb/sdwp_host_model.sv ----
`timescale 1ns/1ps
// Host serial master: all pins change on the falling clk edge
module sdwp_host_model (
  input wire logic clk,
  output logic frame_sel_n,
  output logic sclk,
  output logic sdata
);
  // Idle: select high, serial clock parked high between frames
  initial begin
    frame_sel_n = 1'b1;
    sclk = 1'b1;
    sdata = 1'b0;
  end
  // 16 clk cycles per half gives 80 ns, well inside both rate limits
  task automatic half();
    repeat (16) @(negedge clk);
  endtask
  // Sends nbits of w top bit first; under 24 aborts, over 24 repeats the word
  task automatic frame(input logic [23:0] w, input int nbits);
    logic [23:0] sr;
    sr = w;
    frame_sel_n = 1'b0;
    half();
    for (int i = 0; i < nbits; i++) begin
      sdata = sr[23];
      sr = {sr[22:0], sr[23]};
      half();
      sclk = 1'b0;
      half();
      sclk = 1'b1;
    end
    half();
    frame_sel_n = 1'b1;
    sdata = ~sdata; // Released line must not keep its last level
    repeat (40) @(negedge clk);
  endtask
endmodule

// ---- tb/sdwp_top_tb.sv ----
`timescale 1ns/1ps
`define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin n_fail++; \
  $display("[ERR] t=%0t got %0h exp %0h", $time, (a), (e)); end end
module sdwp_top_tb;
  logic clk, reset, frame_sel_n, sclk, sdata;
  logic [15:0] dac_code;
  logic [1:0] power_mode;
  logic power_mode_hi, power_mode_lo, analog_output_en, pulldown_1k, pulldown_100k;
  logic update_pulse;
  int n_fail = 0;
  int tests_run = 0;
  int n_upd = 0;
  sdwp_top u_sdwp_top (.clk(clk), .reset(reset), .frame_sel_n(frame_sel_n), .sclk(sclk),
    .sdata(sdata), .dac_code(dac_code), .power_mode(power_mode),
    .power_mode_hi(power_mode_hi), .power_mode_lo(power_mode_lo),
    .analog_output_en(analog_output_en), .pulldown_1k(pulldown_1k),
    .pulldown_100k(pulldown_100k), .update_pulse(update_pulse));
  sdwp_host_model u_sdwp_host_model (.clk(clk), .frame_sel_n(frame_sel_n), .sclk(sclk),
    .sdata(sdata));
  // 200 MHz clock
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // Count update pulses so a missing or extra load is seen without timing guesses
  always @(negedge clk) begin
    if (update_pulse === 1'b1) n_upd++;
  end
  task automatic close_out();
    if (n_fail == 0 && tests_run > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // Compares every output except update_pulse against the expected code and mode
  task automatic chk_out(input logic [15:0] code, input logic [1:0] mode);
    `CHK(dac_code, code)
    `CHK(power_mode, mode)
    `CHK({power_mode_hi, power_mode_lo}, mode)
    `CHK(analog_output_en, mode == 2'b00)
    `CHK(pulldown_1k, mode == 2'b01)
    `CHK(pulldown_100k, mode == 2'b10)
  endtask
  task automatic t_reset();
    chk_out(16'h0000, 2'b00);
    `CHK(n_upd, 0)
  endtask
  // Aborts at 0, 1 and 23 bits leave all outputs alone; a clean frame then loads
  task automatic t_abort(input logic [15:0] code, input logic [1:0] mode);
    int nb[3];
    int base;
    nb = '{0, 1, 23};
    base = n_upd;
    for (int k = 0; k < 3; k++) begin
      u_sdwp_host_model.frame({6'h3F, ~mode, ~code}, nb[k]);
      `CHK(n_upd, base)
      chk_out(code, mode);
    end
    u_sdwp_host_model.frame({6'h00, 2'b00, ~code}, 24);
    `CHK(n_upd, base + 1)
    chk_out(~code, 2'b00);
  endtask
  // Every power mode once, ignored leading bits set to ones
  task automatic t_modes();
    logic [15:0] codes[4];
    int base;
    codes = '{16'h8001, 16'hFFFE, 16'h0001, 16'h5A3C};
    base = n_upd;
    for (int m = 0; m < 4; m++) begin
      u_sdwp_host_model.frame({6'h3F, 2'(m), codes[m]}, 24);
      `CHK(n_upd, base + m + 1)
      chk_out(codes[m], 2'(m));
    end
  endtask
  // Two clocks past the 24th are ignored; the load stays on the 24th edge
  task automatic t_extra();
    int base;
    base = n_upd;
    u_sdwp_host_model.frame({6'h00, 2'b01, 16'h1234}, 26);
    `CHK(n_upd, base + 1)
    chk_out(16'h1234, 2'b01);
  endtask
  // Reset in mid-run returns code and mode to their power-up values
  task automatic t_midreset();
    int base;
    base = n_upd;
    reset = 1'b1;
    repeat (5) @(negedge clk);
    reset = 1'b0;
    repeat (4) @(negedge clk);
    `CHK(n_upd, base)
    chk_out(16'h0000, 2'b00);
  endtask
  // Hang guard
  initial begin
    #200000;
    n_fail++;
    close_out();
  end
  initial begin
    reset = 1'b1;
    repeat (5) @(negedge clk);
    reset = 1'b0;
    repeat (4) @(negedge clk);
    t_reset();
    t_abort(16'h0000, 2'b00);
    t_modes();
    t_abort(16'h5A3C, 2'b11);
    t_extra();
    t_midreset();
    close_out();
  end
endmodule
